// ==== pin_mode_pkg.sv ====
// Purpose: Shared constants for the local bus pin-mode interface.
// Assumes: Bus clock is a separate domain supplied by the bus controller.
// Notes: Mode encoding and reset values live here.
package pin_mode_pkg;
  localparam logic MODE_THREE_PIN = 1'h0;
  localparam logic MODE_FIVE_PIN = 1'h1;
  localparam logic OE_RESET = 1'h0;
  localparam logic LINE_RESET = 1'h0;
  localparam int SYNC_STAGES = 2;
endpackage

// ==== bus_pin_mux.sv ====
// Purpose: Pin multiplexing and driver control of the local serial bus.
// Assumes: RST_I is synchronous to SYS_CLK_I; the bus clock runs only from the controller.
// Notes: Transmit data and slot strobes arrive from bus-clock-domain logic.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - In three-pin mode drive the shared data line only while transmitting.
// - In five-pin mode never drive the shared data line; receive only.
// - Signal line carries controller address and device command and status in slots.
// - In five-pin mode never enable a driver on the shared signal line.
// - Outgoing data uses the five-pin data output only in five-pin mode.
// - Outgoing signal bytes use the five-pin signal output only in five-pin mode.
module bus_pin_mux
  import pin_mode_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic ENABLE_I,
  input wire logic FIVE_PIN_I,
  input wire logic BUS_CLOCK_IN,
  input wire logic DATA_TX_I,
  input wire logic DATA_TX_VALID_I,
  input wire logic SIG_TX_I,
  input wire logic SIG_SLOT_I,
  input wire logic SHARED_DATA_LINE_I,
  output logic SHARED_DATA_LINE_O,
  output logic SHARED_DATA_LINE_OE_O,
  input wire logic SHARED_SIGNAL_LINE_I,
  output logic SHARED_SIGNAL_LINE_O,
  output logic SHARED_SIGNAL_LINE_OE_O,
  output logic DATA_OUT_FIVE_PIN_O,
  output logic DATA_OUT_FIVE_PIN_OE_O,
  output logic SIGNAL_OUT_FIVE_PIN_O,
  output logic SIGNAL_OUT_FIVE_PIN_OE_O,
  output logic DATA_RX_O,
  output logic SIG_RX_O,
  output logic ACTIVE_O
);

  // ==========================================================
  // Reset and mode crossing into the bus clock domain.
  logic [SYNC_STAGES-1:0] rst_sync_q;
  logic [SYNC_STAGES-1:0] en_sync_q;
  logic [SYNC_STAGES-1:0] mode_sync_q;
  logic en_hold_q, en_hold_d;
  logic mode_hold_q, mode_hold_d;
  logic [SYNC_STAGES-1:0] rst_sync_d;
  logic [SYNC_STAGES-1:0] en_sync_d;
  logic [SYNC_STAGES-1:0] mode_sync_d;

  always_comb begin
    en_hold_d = RST_I ? 1'h0 : ENABLE_I;
    mode_hold_d = RST_I ? MODE_THREE_PIN : FIVE_PIN_I;
  end

  always_ff @(posedge SYS_CLK_I) begin
    en_hold_q <= en_hold_d;
    mode_hold_q <= mode_hold_d;
  end

  // The second stage alone is read by the pin logic.
  always_comb begin
    rst_sync_d = {rst_sync_q[0], RST_I};
    en_sync_d = {en_sync_q[0], en_hold_q};
    mode_sync_d = {mode_sync_q[0], mode_hold_q};
  end

  always_ff @(posedge BUS_CLOCK_IN) begin
    rst_sync_q <= rst_sync_d;
    en_sync_q <= en_sync_d;
    mode_sync_q <= mode_sync_d;
  end

  // ==========================================================
  // Driver control in the bus clock domain.
  logic dat_oe_q, dat_oe_d, dat_q, dat_d;
  logic sig_oe_q, sig_oe_d, sig_q, sig_d;
  logic do_oe_q, do_oe_d, do_q, do_d;
  logic so_oe_q, so_oe_d, so_q, so_d;
  logic rx_dat_q, rx_dat_d, rx_sig_q, rx_sig_d;
  logic run_q, run_d;
  logic run;
  logic five;

  always_comb begin
    run = en_sync_q[1] & ~rst_sync_q[1];
    five = mode_sync_q[1];
    dat_oe_d = run & ~five & DATA_TX_VALID_I;
    sig_oe_d = run & ~five & SIG_SLOT_I;
    do_oe_d = run & five & DATA_TX_VALID_I;
    so_oe_d = run & five & SIG_SLOT_I;
    dat_d = dat_oe_d ? DATA_TX_I : LINE_RESET;
    sig_d = sig_oe_d ? SIG_TX_I : LINE_RESET;
    do_d = do_oe_d ? DATA_TX_I : LINE_RESET;
    so_d = so_oe_d ? SIG_TX_I : LINE_RESET;
    run_d = run;
    rx_dat_d = SHARED_DATA_LINE_I;
    rx_sig_d = SHARED_SIGNAL_LINE_I;
  end

  always_ff @(posedge BUS_CLOCK_IN) begin
    if (rst_sync_q[1]) begin
      dat_oe_q <= OE_RESET;
      sig_oe_q <= OE_RESET;
      do_oe_q <= OE_RESET;
      so_oe_q <= OE_RESET;
      dat_q <= LINE_RESET;
      sig_q <= LINE_RESET;
      do_q <= LINE_RESET;
      so_q <= LINE_RESET;
    end else begin
      dat_oe_q <= dat_oe_d;
      sig_oe_q <= sig_oe_d;
      do_oe_q <= do_oe_d;
      so_oe_q <= so_oe_d;
      dat_q <= dat_d;
      sig_q <= sig_d;
      do_q <= do_d;
      so_q <= so_d;
    end
    run_q <= run_d;
    rx_dat_q <= rx_dat_d;
    rx_sig_q <= rx_sig_d;
  end

  // ==========================================================
  // Activity status back in the system clock domain.
  logic [SYNC_STAGES-1:0] act_sync_q;
  logic act_q, act_d;

  always_comb begin
    act_d = RST_I ? 1'h0 : act_sync_q[1];
  end

  always_ff @(posedge SYS_CLK_I) begin
    act_sync_q <= {act_sync_q[0], run_q};
    act_q <= act_d;
  end

  assign SHARED_DATA_LINE_O = dat_q;
  assign SHARED_DATA_LINE_OE_O = dat_oe_q;
  assign SHARED_SIGNAL_LINE_O = sig_q;
  assign SHARED_SIGNAL_LINE_OE_O = sig_oe_q;
  assign DATA_OUT_FIVE_PIN_O = do_q;
  assign DATA_OUT_FIVE_PIN_OE_O = do_oe_q;
  assign SIGNAL_OUT_FIVE_PIN_O = so_q;
  assign SIGNAL_OUT_FIVE_PIN_OE_O = so_oe_q;
  assign DATA_RX_O = rx_dat_q;
  assign SIG_RX_O = rx_sig_q;
  assign ACTIVE_O = act_q;

  // ==========================================================
  // Checks.
  sequence five_mode_s;
    mode_sync_q[1] == MODE_FIVE_PIN;
  endsequence

  sequence three_mode_s;
    mode_sync_q[1] == MODE_THREE_PIN;
  endsequence

  sequence tx_three_s;
    run && !five && DATA_TX_VALID_I;
  endsequence

  sequence tx_five_s;
    run && five && DATA_TX_VALID_I;
  endsequence

  sequence slot_three_s;
    run && !five && SIG_SLOT_I;
  endsequence

  sequence slot_five_s;
    run && five && SIG_SLOT_I;
  endsequence

  five_no_data_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    five_mode_s |=> !dat_oe_q) else $error("Data line driven in five-pin mode.");
  five_no_sig_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    five_mode_s |=> !sig_oe_q) else $error("Signal line driven in five-pin mode.");
  three_no_do_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    three_mode_s |=> !do_oe_q) else $error("Data output used in three-pin mode.");
  three_no_so_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    three_mode_s |=> !so_oe_q) else $error("Signal output used in three-pin mode.");
  data_tx_drive_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    tx_three_s |=> (dat_oe_q && dat_q == $past(DATA_TX_I)))
    else $error("Data line not driven while transmitting.");
  five_data_drive_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    tx_five_s |=> (do_oe_q && do_q == $past(DATA_TX_I)))
    else $error("Data output not driven while transmitting.");
  three_sig_drive_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    slot_three_s |=> (sig_oe_q && sig_q == $past(SIG_TX_I)))
    else $error("Signal line not driven in slot.");
  five_sig_drive_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    slot_five_s |=> (so_oe_q && so_q == $past(SIG_TX_I)))
    else $error("Signal output not driven in slot.");
  data_rx_sample_a: assert property (@(posedge BUS_CLOCK_IN)
    1'b1 |=> rx_dat_q == $past(SHARED_DATA_LINE_I))
    else $error("Data line not sampled.");
  sig_rx_sample_a: assert property (@(posedge BUS_CLOCK_IN)
    1'b1 |=> rx_sig_q == $past(SHARED_SIGNAL_LINE_I))
    else $error("Signal line not sampled.");
  sig_slot_drive_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    (run && !mode_sync_q[1] && !SIG_SLOT_I) |=> !sig_oe_q) else $error("Signal line driven outside slot.");
  reset_quiet_a: assert property (@(posedge BUS_CLOCK_IN)
    rst_sync_q[1] |=> !(dat_oe_q || sig_oe_q || do_oe_q || so_oe_q)) else $error("Driver on during reset.");
  disabled_quiet_a: assert property (@(posedge BUS_CLOCK_IN) disable iff (rst_sync_q[1])
    !en_sync_q[1] |=> !(dat_oe_q || sig_oe_q || do_oe_q || so_oe_q)) else $error("Driver on while disabled.");

endmodule // bus_pin_mux

`default_nettype wire

// ==== bus_ctrl_model.sv ====
// Purpose: Bus controller model: makes the bus clock and drives the lines.
// Assumes: Bus clock runs free at an 80 ns period.
// Notes: Controller drives a line whenever the device does not.
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  output logic BUS_CLK_O,
  input wire logic DAT_I,
  input wire logic SIG_I,
  input wire logic DEV_DAT_OE_I,
  input wire logic DEV_DAT_I,
  input wire logic DEV_SIG_OE_I,
  input wire logic DEV_SIG_I,
  output logic DAT_LINE_O,
  output logic SIG_LINE_O
);
  initial begin
    BUS_CLK_O = 1'h0;
    #3;
    forever #40 BUS_CLK_O = ~BUS_CLK_O;
  end
  assign DAT_LINE_O = DEV_DAT_OE_I ? DEV_DAT_I : DAT_I;
  assign SIG_LINE_O = DEV_SIG_OE_I ? DEV_SIG_I : SIG_I;
endmodule // bus_ctrl_model
`default_nettype wire

// ==== bus_pin_mux_tb.sv ====
// Purpose: Self-checking bench of the pin multiplexer.
// Assumes: Mode changes settle within four bus cycles.
// Notes: Bus-side inputs change at the bus clock falling edge.
`timescale 1ns/1ps
`default_nettype none
module bus_pin_mux_tb;
  import pin_mode_pkg::*;
  logic clk = 0, rst = 1, en = 0, five = 0, dtx = 0, dv = 0, stx = 0, slot = 0, cd = 0, cs = 0;
  logic bclk, dl, sl_w, d_o, d_oe, s_o, s_oe, do_o, do_oe, so_o, so_oe, drx, srx, act;
  int err_count = 0, compares = 0;
  always #5 clk = ~clk;
  bus_ctrl_model i_bus_ctrl_model (.BUS_CLK_O(bclk), .DAT_I(cd), .SIG_I(cs), .DEV_DAT_OE_I(d_oe),
    .DEV_DAT_I(d_o), .DEV_SIG_OE_I(s_oe), .DEV_SIG_I(s_o), .DAT_LINE_O(dl), .SIG_LINE_O(sl_w));
  bus_pin_mux i_bus_pin_mux (.SYS_CLK_I(clk), .RST_I(rst), .ENABLE_I(en), .FIVE_PIN_I(five),
    .BUS_CLOCK_IN(bclk), .DATA_TX_I(dtx), .DATA_TX_VALID_I(dv), .SIG_TX_I(stx), .SIG_SLOT_I(slot),
    .SHARED_DATA_LINE_I(dl), .SHARED_DATA_LINE_O(d_o), .SHARED_DATA_LINE_OE_O(d_oe),
    .SHARED_SIGNAL_LINE_I(sl_w), .SHARED_SIGNAL_LINE_O(s_o), .SHARED_SIGNAL_LINE_OE_O(s_oe),
    .DATA_OUT_FIVE_PIN_O(do_o), .DATA_OUT_FIVE_PIN_OE_O(do_oe), .SIGNAL_OUT_FIVE_PIN_O(so_o),
    .SIGNAL_OUT_FIVE_PIN_OE_O(so_oe), .DATA_RX_O(drx), .SIG_RX_O(srx), .ACTIVE_O(act));
  task automatic chk(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic oe_off;
    chk("any_oe", 1'h0, d_oe | s_oe | do_oe | so_oe);
  endtask
  task automatic tx_case(input logic v, input logic d, input logic sl, input logic s);
    @(negedge bclk);
    dv = v;
    dtx = d;
    slot = sl;
    stx = s;
    cd = d;
    cs = s;
    @(negedge bclk);
    chk("data_oe", v & ~five, d_oe);
    chk("sig_oe", sl & ~five, s_oe);
    chk("dout_oe", v & five, do_oe);
    chk("sout_oe", sl & five, so_oe);
    if (v) chk("data", d, five ? do_o : d_o);
    if (sl) chk("sig", s, five ? so_o : s_o);
    if (five) chk("data_rx", d, drx);
    if (five) chk("sig_rx", s, srx);
  endtask
  task automatic mode_run(input logic m);
    @(negedge clk);
    five = m;
    repeat (4) @(negedge bclk);
    for (int i = 0; i < 8; i++) tx_case(i[0], i[1], i[2], ~i[1]);
  endtask
  task automatic final_report;
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    final_report;
  end
  initial begin
    dv = 1;
    slot = 1;
    repeat (16) @(posedge clk);
    repeat (4) @(negedge bclk);
    oe_off;
    chk("active", 1'h0, act);
    @(negedge clk);
    rst = 0;
    repeat (4) @(negedge bclk);
    oe_off;
    @(negedge clk);
    en = 1;
    repeat (6) @(negedge bclk);
    chk("active", 1'h1, act);
    mode_run(MODE_THREE_PIN);
    mode_run(MODE_FIVE_PIN);
    @(negedge bclk);
    dv = 1;
    slot = 1;
    @(negedge clk);
    en = 0;
    repeat (6) @(negedge bclk);
    oe_off;
    chk("active", 1'h0, act);
    final_report;
  end
endmodule // bus_pin_mux_tb
`default_nettype wire
